// ===== rtl/crx_pkg.sv
package crx_pkg;
  localparam int WORD_W = 24;
  localparam int MASK_W = 12;
  localparam int IDX_W = 3;
  localparam int COND_W = 6;
  localparam int PAGE_W = 12;
  localparam int PAGE_AW = 6;
  localparam int CMP_W = 15;
  localparam int CHAR_W = 17;
  localparam int FAULT_W = 12;
  localparam int CHAN_CLR_W = 12;
  localparam int BUSY_W = 12;
  localparam int STAT_W = 12;
  localparam int CH_W = 3;
  localparam int AUX_IDX_W = 15;
  localparam int MEM_AW = 18;
  localparam int CLK_MHZ = 25;
  localparam int PAUSE_MS = 40;
  localparam int PAUSE_CYC = PAUSE_MS * 1000 * CLK_MHZ;
  localparam int PROBE_US = 5;
  localparam int PROBE_CYC = (PROBE_US * CLK_MHZ > 0) ? PROBE_US * CLK_MHZ : 1;
  // octal 7777777: the fill pattern a destructive load leaves behind
  localparam logic [WORD_W-1:0] DESTRUCT_WORD = 24'h1FFFFF;
  localparam logic [1:0] REL_EQ = 2'h0;
  localparam logic [1:0] REL_NE = 2'h1;
  localparam logic [1:0] REL_GE = 2'h2;
  localparam logic [1:0] REL_LT = 2'h3;

  typedef enum logic [4:0] {
    CRX_NOP, CRX_MASK_SET, CRX_MASK_CLR, CRX_ACC_TO_CI, CRX_CI_TO_ACC,
    CRX_ACC_TO_OS, CRX_OS_TO_ACC, CRX_ACC_TO_IS, CRX_IS_TO_ACC,
    CRX_COND_TO_ACC, CRX_ACC_TO_COND, CRX_ACC_TO_PAGE, CRX_PAGE_TO_ACC,
    CRX_BUSY_WAIT, CRX_PRIO_WAIT, CRX_MEM_PROBE, CRX_BJ_ARM, CRX_DL_ARM,
    CRX_IRQ_EN, CRX_IRQ_DIS, CRX_SEL_STOP, CRX_HALT, CRX_CHAN_CLR,
    CRX_ACC_EQ_SKIP, CRX_AUX_JUMP, CRX_ENTER_CHAR, CRX_ENTER_CHAR_S,
    CRX_LOCKOUT, CRX_FAULT_CLR, CRX_STATUS_COPY, CRX_JUMP, CRX_LOAD_ACC
  } crx_op_t;

  typedef enum logic [1:0] {CRX_IDLE, CRX_WAIT, CRX_PROBE, CRX_STOP} crx_st_t;

  typedef struct packed {
    crx_op_t op;
    logic [WORD_W-1:0] operand;
    logic [1:0] rel;
    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] aux;
    logic [AUX_IDX_W-1:0] idx2;
    logic [CH_W-1:0] ch;
  } crx_cmd_t;

  typedef struct packed {
    logic done;
    logic [1:0] next_sel;
    logic acc_we;
    logic [WORD_W-1:0] acc;
  } crx_res_t;

  localparam logic [1:0] NEXT_P1 = 2'h0;
  localparam logic [1:0] NEXT_P2 = 2'h1;
  localparam logic [1:0] NEXT_M = 2'h2;
endpackage : crx_pkg

// ===== rtl/crx_exec.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
module crx_exec #(
  parameter int PAUSE_CYCLES = crx_pkg::PAUSE_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire crx_pkg::crx_cmd_t i_cmd,
  input wire logic [crx_pkg::BUSY_W-1:0] i_busy,
  input wire logic [crx_pkg::STAT_W-1:0] i_ext_status,
  input wire logic [crx_pkg::FAULT_W-1:0] i_fault_set,
  input wire logic [crx_pkg::MASK_W-1:0] i_chan_irq,
  input wire logic i_sel_stop_sw,
  input wire logic i_restart,
  input wire logic i_mem_reply,
  input wire logic i_irq_pending,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  input wire logic [3:0] i_reg_addr,
  input wire logic [crx_pkg::WORD_W-1:0] i_reg_wdata,
  output logic [crx_pkg::WORD_W-1:0] o_reg_rdata,
  output crx_pkg::crx_res_t o_res,
  output logic o_busy,
  output logic o_halted,
  output logic o_rtc_freeze,
  output logic o_mem_req,
  output logic [crx_pkg::MEM_AW-1:0] o_mem_addr,
  output logic o_mem_we,
  output logic [crx_pkg::WORD_W-1:0] o_mem_wdata,
  output logic o_irq_take,
  output logic o_program_state,
  output logic [crx_pkg::CHAN_CLR_W-1:0] o_chan_clear,
  output logic [crx_pkg::MASK_W-1:0] o_chan_irq_gated,
  output logic [crx_pkg::FAULT_W-1:0] o_faults
);

  localparam logic [3:0] RA_MASK = 4'h0;
  localparam logic [3:0] RA_STATE = 4'h1;
  localparam logic [3:0] RA_FAULT = 4'h2;
  localparam logic [3:0] RA_CTRL = 4'h3;

  typedef struct packed {
    crx_pkg::crx_st_t st;
    logic [31:0] cnt;
    logic prio;
    logic [crx_pkg::MASK_W-1:0] wmask;
    logic [crx_pkg::MASK_W-1:0] mask;
    logic [crx_pkg::IDX_W-1:0] ci;
    logic [crx_pkg::IDX_W-1:0] os;
    logic [crx_pkg::IDX_W-1:0] is_r;
    logic [crx_pkg::COND_W-1:0] cond;
    logic [crx_pkg::FAULT_W-1:0] faults;
    logic [crx_pkg::MASK_W-1:0] lockout;
    logic irq_en;
    logic irq_grace;
    logic bj_armed;
    logic prog_state;
    logic dl_armed;
    logic use_os;
    logic [crx_pkg::CHAN_CLR_W-1:0] chan_clr;
    logic mem_req;
    logic [crx_pkg::MEM_AW-1:0] mem_addr;
    logic mem_we;
    logic [crx_pkg::WORD_W-1:0] mem_wdata;
    crx_pkg::crx_res_t res;
    logic [crx_pkg::WORD_W-1:0] rdata;
  } crx_state_t;

  crx_state_t s_reg;
  crx_state_t s_next;
  logic [crx_pkg::PAGE_W-1:0] page_reg [2**crx_pkg::PAGE_AW];
  logic page_we;
  logic [crx_pkg::PAGE_AW-1:0] page_idx;

  assign page_idx = i_cmd.operand[crx_pkg::PAGE_AW-1:0];
  assign page_we = i_start && !o_busy && i_cmd.op == crx_pkg::CRX_ACC_TO_PAGE;

  genvar g;
  generate
    for (g = 0; g < 2**crx_pkg::PAGE_AW; g++) begin : g_page
      always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          page_reg[g] <= '0;
        end else if (page_we && page_idx == (crx_pkg::PAGE_AW)'(g)) begin
          page_reg[g] <= i_cmd.acc[crx_pkg::PAGE_W-1:0];
        end
      end
    end
  endgenerate

  function automatic logic rel_true(input logic [1:0] r, input logic [23:0] a, input logic [23:0] q);
    logic eq;
    logic ge;
    eq = (a == q);
    ge = ($signed(a) >= $signed(q));
    case (r)
      crx_pkg::REL_EQ: rel_true = eq;
      crx_pkg::REL_NE: rel_true = !eq;
      crx_pkg::REL_GE: rel_true = ge;
      default: rel_true = !ge;
    endcase
  endfunction : rel_true

  always_comb begin
    logic [crx_pkg::WORD_W-1:0] x;
    logic [crx_pkg::MASK_W-1:0] xm;
    x = i_cmd.operand;
    xm = x[crx_pkg::MASK_W-1:0];
    s_next = s_reg;
    s_next.res = '0;
    s_next.chan_clr = '0;
    s_next.mem_req = 1'b0;
    s_next.mem_we = 1'b0;
    s_next.rdata = '0;
    s_next.faults = s_reg.faults | i_fault_set;
    // a channel leaves lockout once it is no longer busy
    s_next.lockout = s_reg.lockout & i_busy;
    if (s_reg.irq_grace && i_start && !o_busy) begin
      s_next.irq_grace = 1'b0;
    end
    case (s_reg.st)
      crx_pkg::CRX_IDLE: begin
        if (i_start) begin
          s_next.res.done = 1'b1;
          s_next.res.next_sel = crx_pkg::NEXT_P1;
          case (i_cmd.op)
            crx_pkg::CRX_MASK_SET: s_next.mask = s_reg.mask | xm;
            crx_pkg::CRX_MASK_CLR: s_next.mask = s_reg.mask & ~xm;
            crx_pkg::CRX_ACC_TO_CI: s_next.ci = i_cmd.acc[crx_pkg::IDX_W-1:0];
            crx_pkg::CRX_CI_TO_ACC: begin
              s_next.res.acc_we = 1'b1;
              s_next.res.acc = {{(crx_pkg::WORD_W-crx_pkg::IDX_W){1'b0}}, s_reg.ci};
            end
            crx_pkg::CRX_ACC_TO_OS: s_next.os = i_cmd.acc[crx_pkg::IDX_W-1:0];
            crx_pkg::CRX_OS_TO_ACC: begin
              s_next.res.acc_we = 1'b1;
              s_next.res.acc = {{(crx_pkg::WORD_W-crx_pkg::IDX_W){1'b0}}, s_reg.os};
            end
            crx_pkg::CRX_ACC_TO_IS: s_next.is_r = i_cmd.acc[crx_pkg::IDX_W-1:0];
            crx_pkg::CRX_IS_TO_ACC: begin
              s_next.res.acc_we = 1'b1;
              s_next.res.acc = {{(crx_pkg::WORD_W-crx_pkg::IDX_W){1'b0}}, s_reg.is_r};
            end
            crx_pkg::CRX_COND_TO_ACC: begin
              s_next.res.acc_we = 1'b1;
              s_next.res.acc = {{(crx_pkg::WORD_W-crx_pkg::COND_W){1'b0}}, s_reg.cond};
            end
            crx_pkg::CRX_ACC_TO_COND: s_next.cond = i_cmd.acc[crx_pkg::COND_W-1:0];
            crx_pkg::CRX_PAGE_TO_ACC: begin
              s_next.res.acc_we = 1'b1;
              s_next.res.acc = {{(crx_pkg::WORD_W-crx_pkg::PAGE_W){1'b0}}, page_reg[page_idx]};
            end
            crx_pkg::CRX_BUSY_WAIT, crx_pkg::CRX_PRIO_WAIT: begin
              s_next.wmask = xm;
              s_next.prio = (i_cmd.op == crx_pkg::CRX_PRIO_WAIT);
              s_next.cnt = '0;
              if ((i_busy & xm) != '0) begin
                s_next.res.done = 1'b0;
                s_next.st = crx_pkg::CRX_WAIT;
              end else begin
                s_next.res.next_sel = crx_pkg::NEXT_P2;
              end
            end
            crx_pkg::CRX_MEM_PROBE: begin
              s_next.res.done = 1'b0;
              s_next.cnt = '0;
              s_next.mem_req = 1'b1;
              s_next.mem_addr = {(s_reg.use_os ? s_reg.os : {crx_pkg::IDX_W{1'b0}}), i_cmd.idx2};
              s_next.st = crx_pkg::CRX_PROBE;
            end
            crx_pkg::CRX_BJ_ARM: s_next.bj_armed = 1'b1;
            crx_pkg::CRX_DL_ARM: s_next.dl_armed = 1'b1;
            crx_pkg::CRX_JUMP: begin
              s_next.res.next_sel = crx_pkg::NEXT_M;
              if (s_reg.bj_armed) begin
                s_next.bj_armed = 1'b0;
                s_next.prog_state = 1'b1;
              end
            end
            crx_pkg::CRX_LOAD_ACC: begin
              if (s_reg.dl_armed) begin
                // only this one load is destructive
                s_next.dl_armed = 1'b0;
                s_next.mem_we = 1'b1;
                s_next.mem_addr = i_cmd.operand[crx_pkg::MEM_AW-1:0];
                s_next.mem_wdata = crx_pkg::DESTRUCT_WORD;
              end
            end
            crx_pkg::CRX_IRQ_EN: begin
              s_next.irq_en = 1'b1;
              s_next.irq_grace = 1'b1;
            end
            crx_pkg::CRX_IRQ_DIS: s_next.irq_en = 1'b0;
            crx_pkg::CRX_SEL_STOP: begin
              if (i_sel_stop_sw) begin
                s_next.res.done = 1'b0;
                s_next.st = crx_pkg::CRX_STOP;
              end
            end
            crx_pkg::CRX_HALT: begin
              s_next.res.done = 1'b0;
              s_next.st = crx_pkg::CRX_STOP;
            end
            crx_pkg::CRX_CHAN_CLR: begin
              s_next.chan_clr = {x[11], 2'h0, x[8], x[7:0]};
            end
            crx_pkg::CRX_ACC_EQ_SKIP: begin
              if (i_cmd.acc[crx_pkg::CMP_W-1:0] == x[crx_pkg::CMP_W-1:0]) begin
                s_next.res.next_sel = crx_pkg::NEXT_P2;
              end
            end
            crx_pkg::CRX_AUX_JUMP: begin
              if (rel_true(i_cmd.rel, i_cmd.acc, i_cmd.aux)) begin
                s_next.res.next_sel = crx_pkg::NEXT_M;
                if (s_reg.bj_armed) begin
                  s_next.bj_armed = 1'b0;
                  s_next.prog_state = 1'b1;
                end
              end
            end
            crx_pkg::CRX_ENTER_CHAR: begin
              s_next.res.acc_we = 1'b1;
              s_next.res.acc = {{(crx_pkg::WORD_W-crx_pkg::CHAR_W){1'b0}}, x[crx_pkg::CHAR_W-1:0]};
            end
            crx_pkg::CRX_ENTER_CHAR_S: begin
              s_next.res.acc_we = 1'b1;
              s_next.res.acc = {{(crx_pkg::WORD_W-crx_pkg::CHAR_W){x[crx_pkg::CHAR_W-1]}},
                                x[crx_pkg::CHAR_W-1:0]};
            end
            crx_pkg::CRX_LOCKOUT: s_next.lockout = (s_reg.lockout | xm) & i_busy;
            crx_pkg::CRX_FAULT_CLR: begin
              // a fault raised in the same cycle survives the clear
              s_next.faults = (s_reg.faults & ~x[crx_pkg::FAULT_W-1:0]) | i_fault_set;
            end
            crx_pkg::CRX_STATUS_COPY: begin
              s_next.res.acc_we = 1'b1;
              s_next.res.acc = {s_reg.mask, i_ext_status};
            end
            default: begin
            end
          endcase
        end
      end
      crx_pkg::CRX_WAIT: begin
        if ((i_busy & s_reg.wmask) == '0) begin
          s_next.res.done = 1'b1;
          s_next.res.next_sel = crx_pkg::NEXT_P2;
          s_next.st = crx_pkg::CRX_IDLE;
        end else if (s_reg.cnt >= 32'(PAUSE_CYCLES - 1)) begin
          s_next.res.done = 1'b1;
          s_next.res.next_sel = crx_pkg::NEXT_P1;
          s_next.st = crx_pkg::CRX_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt + 32'h1;
        end
      end
      crx_pkg::CRX_PROBE: begin
        if (i_mem_reply) begin
          s_next.res.done = 1'b1;
          s_next.res.next_sel = crx_pkg::NEXT_P2;
          s_next.st = crx_pkg::CRX_IDLE;
        end else if (s_reg.cnt >= 32'(crx_pkg::PROBE_CYC - 1)) begin
          s_next.res.done = 1'b1;
          s_next.res.next_sel = crx_pkg::NEXT_P1;
          s_next.st = crx_pkg::CRX_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt + 32'h1;
        end
      end
      default: begin
        if (i_restart) begin
          s_next.res.done = 1'b1;
          s_next.res.next_sel = crx_pkg::NEXT_P1;
          s_next.st = crx_pkg::CRX_IDLE;
        end
      end
    endcase
    // software side: mask, states, faults, control
    if (i_reg_we) begin
      if (i_reg_addr == RA_MASK) begin
        s_next.mask = i_reg_wdata[crx_pkg::MASK_W-1:0];
      end else if (i_reg_addr == RA_CTRL) begin
        s_next.use_os = i_reg_wdata[0];
      end
    end
    if (i_reg_re) begin
      if (i_reg_addr == RA_MASK) begin
        s_next.rdata = {{(crx_pkg::WORD_W-crx_pkg::MASK_W){1'b0}}, s_reg.mask};
      end else if (i_reg_addr == RA_STATE) begin
        s_next.rdata = {8'h0, s_reg.prog_state, s_reg.dl_armed, s_reg.bj_armed, s_reg.irq_en,
                        s_reg.cond, s_reg.is_r, s_reg.os};
      end else if (i_reg_addr == RA_FAULT) begin
        s_next.rdata = {{(crx_pkg::WORD_W-crx_pkg::FAULT_W){1'b0}}, s_reg.faults};
      end else if (i_reg_addr == RA_CTRL) begin
        s_next.rdata = {{(crx_pkg::WORD_W-crx_pkg::IDX_W-1){1'b0}}, s_reg.ci, s_reg.use_os};
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_reg_rdata = s_reg.rdata;
  assign o_res = s_reg.res;
  assign o_busy = s_reg.st != crx_pkg::CRX_IDLE;
  assign o_halted = s_reg.st == crx_pkg::CRX_STOP;
  assign o_rtc_freeze = s_reg.st == crx_pkg::CRX_WAIT && s_reg.prio;
  assign o_mem_req = s_reg.mem_req;
  assign o_mem_addr = s_reg.mem_addr;
  assign o_mem_we = s_reg.mem_we;
  assign o_mem_wdata = s_reg.mem_wdata;
  // the grace instruction must complete before a pending interrupt is taken
  assign o_irq_take = s_reg.irq_en && !s_reg.irq_grace && i_irq_pending && !o_busy;
  assign o_program_state = s_reg.prog_state;
  assign o_chan_clear = s_reg.chan_clr;
  assign o_chan_irq_gated = i_chan_irq & s_reg.mask & ~s_reg.lockout;
  assign o_faults = s_reg.faults;

  a_mask_set_bits: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_start && !o_busy && i_cmd.op == crx_pkg::CRX_MASK_SET && !i_reg_we)
      |=> ((s_reg.mask & $past(i_cmd.operand[11:0])) == $past(i_cmd.operand[11:0])))
    else $error("mask set lost a bit");
  a_mask_clr_bits: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_start && !o_busy && i_cmd.op == crx_pkg::CRX_MASK_CLR && !i_reg_we)
      |=> ((s_reg.mask & $past(i_cmd.operand[11:0])) == '0))
    else $error("mask clear left a bit");
  a_status_copy_hi: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_start && !o_busy && i_cmd.op == crx_pkg::CRX_STATUS_COPY)
      |=> (o_res.acc == {$past(s_reg.mask), $past(i_ext_status)} && o_res.acc_we))
    else $error("status copy wrong");
  a_ci_readback: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_start && !o_busy && i_cmd.op == crx_pkg::CRX_ACC_TO_CI) ##2
    (i_start && !o_busy && i_cmd.op == crx_pkg::CRX_CI_TO_ACC)
      |=> (o_res.acc == {21'h0, $past(i_cmd.acc[2:0], 3)}))
    else $error("channel index readback wrong");
  sequence wait_entry_s;
    i_start && !o_busy && (i_cmd.op == crx_pkg::CRX_BUSY_WAIT) && ((i_busy & i_cmd.operand[11:0]) != '0);
  endsequence
  a_wait_holds: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wait_entry_s |=> (o_busy && !o_res.done))
    else $error("busy wait did not hold");
  a_prio_freeze: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_start && !o_busy && ((i_busy & i_cmd.operand[11:0]) != '0) &&
     (i_cmd.op == crx_pkg::CRX_BUSY_WAIT || i_cmd.op == crx_pkg::CRX_PRIO_WAIT))
      |=> (o_rtc_freeze == ($past(i_cmd.op) == crx_pkg::CRX_PRIO_WAIT)))
    else $error("clock freeze wrong");
  a_probe_limit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_start && !o_busy && i_cmd.op == crx_pkg::CRX_MEM_PROBE) |-> ##[1:130] o_res.done)
    else $error("memory probe never ended");
  a_halt_stays: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_start && !o_busy && i_cmd.op == crx_pkg::CRX_HALT && !i_restart) |=> o_halted)
    else $error("halt not taken");
  a_irq_grace: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_start && !o_busy && i_cmd.op == crx_pkg::CRX_IRQ_EN) |=> !o_irq_take)
    else $error("interrupt taken too early");
  a_skip_eq: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_start && !o_busy && i_cmd.op == crx_pkg::CRX_ACC_EQ_SKIP && i_cmd.acc[14:0] == i_cmd.operand[14:0])
      |=> (o_res.next_sel == crx_pkg::NEXT_P2))
    else $error("equal skip missed");

endmodule : crx_exec

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_start = 1'b0;
  crx_pkg::crx_cmd_t i_cmd = '0;
  logic [11:0] i_busy = 12'h000;
  logic [11:0] i_ext_status = 12'h000;
  logic [11:0] i_fault_set = 12'h000;
  logic [11:0] i_chan_irq = 12'h000;
  logic i_sel_stop_sw = 1'b0;
  logic i_restart = 1'b0;
  logic i_mem_reply = 1'b0;
  logic i_irq_pending = 1'b0;
  logic i_reg_we = 1'b0;
  logic i_reg_re = 1'b0;
  logic [3:0] i_reg_addr = 4'h0;
  logic [23:0] i_reg_wdata = 24'h000000;
  logic [23:0] o_reg_rdata;
  crx_pkg::crx_res_t o_res;
  logic o_busy, o_halted, o_rtc_freeze, o_mem_req, o_mem_we, o_irq_take, o_program_state;
  logic [17:0] o_mem_addr;
  logic [23:0] o_mem_wdata;
  logic [11:0] o_chan_clear, o_chan_irq_gated, o_faults;
  int miscompares = 0;
  int n_compared = 0;
  int wcyc, hcnt, mwe_n;
  logic frz_seen, hlt_seen;
  logic [17:0] mreq_addr;
  logic [23:0] mw_data;
  logic [23:0] ld_v[5] = '{24'h3, 24'h5, 24'h6, 24'h2A, 24'hABC};
  int ld_w[5] = '{3, 3, 3, 6, 12};
  crx_pkg::crx_op_t ld_op[5] = '{crx_pkg::CRX_ACC_TO_CI, crx_pkg::CRX_ACC_TO_OS, crx_pkg::CRX_ACC_TO_IS,
    crx_pkg::CRX_ACC_TO_COND, crx_pkg::CRX_ACC_TO_PAGE};
  crx_pkg::crx_op_t rd_op[5] = '{crx_pkg::CRX_CI_TO_ACC, crx_pkg::CRX_OS_TO_ACC, crx_pkg::CRX_IS_TO_ACC,
    crx_pkg::CRX_COND_TO_ACC, crx_pkg::CRX_PAGE_TO_ACC};
  logic [1:0] rel_sel[4] = '{crx_pkg::NEXT_P1, crx_pkg::NEXT_M, crx_pkg::NEXT_P1, crx_pkg::NEXT_M};

  always #20 i_mclk = ~i_mclk;

  crx_exec #(.PAUSE_CYCLES(20)) dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_start(i_start), .i_cmd(i_cmd),
    .i_busy(i_busy), .i_ext_status(i_ext_status), .i_fault_set(i_fault_set), .i_chan_irq(i_chan_irq),
    .i_sel_stop_sw(i_sel_stop_sw), .i_restart(i_restart), .i_mem_reply(i_mem_reply),
    .i_irq_pending(i_irq_pending), .i_reg_we(i_reg_we), .i_reg_re(i_reg_re), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_res(o_res), .o_busy(o_busy),
    .o_halted(o_halted), .o_rtc_freeze(o_rtc_freeze), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
    .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_irq_take(o_irq_take),
    .o_program_state(o_program_state), .o_chan_clear(o_chan_clear), .o_chan_irq_gated(o_chan_irq_gated),
    .o_faults(o_faults));

  // operator restart: released a few cycles into any halt so stops always end
  always @(posedge i_mclk) begin
    hcnt <= (o_halted === 1'b1) ? hcnt + 1 : 0;
    i_restart <= (o_halted === 1'b1) && (hcnt == 3);
    if (o_halted === 1'b1) hlt_seen <= 1'b1;
    if (o_rtc_freeze === 1'b1) frz_seen <= 1'b1;
    if (o_mem_req === 1'b1 || o_mem_we === 1'b1) mreq_addr <= o_mem_addr;
    if (o_mem_we === 1'b1) begin
      mwe_n <= mwe_n + 1;
      mw_data <= o_mem_wdata;
    end
  end

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task reg_wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge i_mclk);
    i_reg_we <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_we <= 1'b0;
  endtask : reg_wr

  task reg_rd(input logic [3:0] a, input logic [23:0] e, input string n);
    @(posedge i_mclk);
    i_reg_re <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_re <= 1'b0;
    #1 chk(n, e, o_reg_rdata);
  endtask : reg_rd

  // issue one instruction and wait, bounded, for its completion; leaves o_res on view
  task ex(input crx_pkg::crx_op_t op, input logic [23:0] x, input logic [23:0] acc, input logic [1:0] sel);
    @(posedge i_mclk);
    i_start <= 1'b1;
    i_cmd.op <= op;
    i_cmd.operand <= x;
    i_cmd.acc <= acc;
    @(posedge i_mclk);
    i_start <= 1'b0;
    #1 wcyc = 0;
    while (o_res.done !== 1'b1 && wcyc < 400) begin
      @(posedge i_mclk);
      #1 wcyc++;
    end
    if (o_res.done !== 1'b1) begin
      miscompares++;
      $display("BAD done expected 1 seen %b", o_res.done);
      print_verdict();
    end
    chk("next_sel", sel, o_res.next_sel);
  endtask : ex

  initial begin
    {hcnt, mwe_n, frz_seen, hlt_seen} = '0;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    for (int a = 0; a < 4; a++) reg_rd(a[3:0], 24'h0, "reset reg");
    reg_rd(4'h9, 24'h0, "unmapped");
    $display("test reset done");
    reg_wr(4'h0, 24'h000A5A);
    ex(crx_pkg::CRX_MASK_SET, 24'h0000F0, 24'h0, crx_pkg::NEXT_P1);
    reg_rd(4'h0, 24'h000AFA, "mask set");
    ex(crx_pkg::CRX_MASK_CLR, 24'h000A30, 24'h0, crx_pkg::NEXT_P1);
    reg_rd(4'h0, 24'h0000CA, "mask clear");
    $display("test mask done");
    for (int k = 0; k < 5; k++) begin
      ex(ld_op[k], 24'h3, (24'hFFFFFF << ld_w[k]) | ld_v[k], crx_pkg::NEXT_P1);
      ex(rd_op[k], 24'h3, 24'hFFFFFF, crx_pkg::NEXT_P1);
      chk("readback", ld_v[k], o_res.acc);
      chk("readback we", 24'h1, o_res.acc_we);
    end
    reg_rd(4'h1, 24'h000AB5, "state reg");
    $display("test transfers done");
    @(posedge i_mclk) i_ext_status <= 12'h123;
    ex(crx_pkg::CRX_STATUS_COPY, 24'h0, 24'h0, crx_pkg::NEXT_P1);
    chk("status copy", 24'h0CA123, o_res.acc);
    ex(crx_pkg::CRX_ENTER_CHAR, 24'h01ABCD, 24'hFFFFFF, crx_pkg::NEXT_P1);
    chk("enter char", 24'h01ABCD, o_res.acc);
    ex(crx_pkg::CRX_ENTER_CHAR_S, 24'h01ABCD, 24'h0, crx_pkg::NEXT_P1);
    chk("enter char signed", 24'hFFABCD, o_res.acc);
    ex(crx_pkg::CRX_ACC_EQ_SKIP, 24'h001234, 24'hFF1234, crx_pkg::NEXT_P2);
    ex(crx_pkg::CRX_ACC_EQ_SKIP, 24'h001235, 24'hFF1234, crx_pkg::NEXT_P1);
    @(posedge i_mclk) i_cmd.aux <= 24'h000007;
    for (int r = 0; r < 4; r++) begin
      @(posedge i_mclk) i_cmd.rel <= r[1:0];
      ex(crx_pkg::CRX_AUX_JUMP, 24'h000100, 24'hFFFFFA, rel_sel[r]);
    end
    $display("test compare done");
    @(posedge i_mclk) i_busy <= 12'h004;
    ex(crx_pkg::CRX_BUSY_WAIT, 24'h000004, 24'h0, crx_pkg::NEXT_P1);
    chk("pause length", 24'h1, (wcyc >= 18 && wcyc <= 22));
    chk("rtc free", 24'h0, frz_seen);
    ex(crx_pkg::CRX_PRIO_WAIT, 24'h000004, 24'h0, crx_pkg::NEXT_P1);
    chk("rtc frozen", 24'h1, frz_seen);
    ex(crx_pkg::CRX_BUSY_WAIT, 24'h000003, 24'h0, crx_pkg::NEXT_P2);
    // busy line drops in mid-pause: the wait must leave by P+2 before its limit
    fork
      ex(crx_pkg::CRX_BUSY_WAIT, 24'h000004, 24'h0, crx_pkg::NEXT_P2);
      begin
        repeat (5) @(posedge i_mclk);
        i_busy <= 12'h000;
        #1 chk("busy held", 24'h1, o_busy);
      end
    join
    $display("test pause done");
    reg_wr(4'h3, 24'h000001);
    @(posedge i_mclk) i_cmd.idx2 <= 15'h1234;
    i_mem_reply <= 1'b1;
    ex(crx_pkg::CRX_MEM_PROBE, 24'h0, 24'h0, crx_pkg::NEXT_P2);
    chk("probe addr", 24'h029234, mreq_addr);
    @(posedge i_mclk) i_mem_reply <= 1'b0;
    ex(crx_pkg::CRX_MEM_PROBE, 24'h0, 24'h0, crx_pkg::NEXT_P1);
    chk("probe time", 24'h1, (wcyc >= crx_pkg::PROBE_CYC - 4 && wcyc <= crx_pkg::PROBE_CYC + 4));
    reg_wr(4'h3, 24'h000000);
    @(posedge i_mclk) i_mem_reply <= 1'b1;
    ex(crx_pkg::CRX_MEM_PROBE, 24'h0, 24'h0, crx_pkg::NEXT_P2);
    chk("probe addr zero", 24'h001234, mreq_addr);
    @(posedge i_mclk) i_mem_reply <= 1'b0;
    $display("test probe done");
    ex(crx_pkg::CRX_LOAD_ACC, 24'h000100, 24'h0, crx_pkg::NEXT_P1);
    ex(crx_pkg::CRX_DL_ARM, 24'h0, 24'h0, crx_pkg::NEXT_P1);
    ex(crx_pkg::CRX_LOAD_ACC, 24'h000100, 24'h0, crx_pkg::NEXT_P1);
    ex(crx_pkg::CRX_LOAD_ACC, 24'h000100, 24'h0, crx_pkg::NEXT_P1);
    chk("destructive writes", 24'h1, mwe_n);
    chk("destructive data", crx_pkg::DESTRUCT_WORD, mw_data);
    chk("destructive addr", 24'h000100, mreq_addr);
    ex(crx_pkg::CRX_BJ_ARM, 24'h0, 24'h0, crx_pkg::NEXT_P1);
    chk("not yet program", 24'h0, o_program_state);
    ex(crx_pkg::CRX_JUMP, 24'h000200, 24'h0, crx_pkg::NEXT_M);
    #40 chk("program state", 24'h1, o_program_state);
    $display("test arm done");
    @(posedge i_mclk) i_irq_pending <= 1'b1;
    ex(crx_pkg::CRX_IRQ_EN, 24'h0, 24'h0, crx_pkg::NEXT_P1);
    chk("irq held one op", 24'h0, o_irq_take);
    ex(crx_pkg::CRX_NOP, 24'h0, 24'h0, crx_pkg::NEXT_P1);
    chk("irq taken", 24'h1, o_irq_take);
    ex(crx_pkg::CRX_IRQ_DIS, 24'h0, 24'h0, crx_pkg::NEXT_P1);
    chk("irq off", 24'h0, o_irq_take);
    @(posedge i_mclk) i_irq_pending <= 1'b0;
    ex(crx_pkg::CRX_SEL_STOP, 24'h0, 24'h0, crx_pkg::NEXT_P1);
    chk("no stop", 24'h0, hlt_seen);
    @(posedge i_mclk) i_sel_stop_sw <= 1'b1;
    ex(crx_pkg::CRX_SEL_STOP, 24'h0, 24'h0, crx_pkg::NEXT_P1);
    chk("sel stop", 24'h1, hlt_seen);
    @(posedge i_mclk) i_sel_stop_sw <= 1'b0;
    hlt_seen <= 1'b0;
    ex(crx_pkg::CRX_HALT, 24'h0, 24'h0, crx_pkg::NEXT_P1);
    chk("halt", 24'h1, hlt_seen);
    ex(crx_pkg::CRX_CHAN_CLR, 24'hFFFFFF, 24'h0, crx_pkg::NEXT_P1);
    chk("chan clear", 24'h0009FF, o_chan_clear);
    $display("test control done");
    @(posedge i_mclk) i_fault_set <= 12'h0F0;
    @(posedge i_mclk) i_fault_set <= 12'h000;
    ex(crx_pkg::CRX_FAULT_CLR, 24'h000030, 24'h0, crx_pkg::NEXT_P1);
    reg_rd(4'h2, 24'h0000C0, "faults");
    chk("fault port", 24'h0000C0, o_faults);
    reg_wr(4'h0, 24'h000FFF);
    @(posedge i_mclk) i_chan_irq <= 12'h003;
    i_busy <= 12'h001;
    ex(crx_pkg::CRX_LOCKOUT, 24'h000001, 24'h0, crx_pkg::NEXT_P1);
    #40 chk("locked out", 24'h002, o_chan_irq_gated);
    @(posedge i_mclk) i_busy <= 12'h000;
    #60 chk("lockout ends", 24'h003, o_chan_irq_gated);
    $display("test faults done");
    print_verdict();
  end
endmodule : testbench
